// file: hw/faog_otp_guard.sv
// Function
// - main array erases in 256 KB sectors except the parameter area
// - lower die takes bottom-parameter or uniform layout
// - upper die takes top-parameter or uniform layout
// - bottom: eight 4 KB, one 224 KB, then 511 of 256 KB
// - top: 511 of 256 KB, one 224 KB, then eight 4 KB
// - uniform: 512 equal 256 KB sectors numbered from zero
// - each small parameter sector is 4 KB aligned and 4 KB long
// - identification read uses its own read-only space
// - parameter read uses own read-only space embedding identification
// - one-time space is 1024 bytes in 32 aligned 32-byte regions
// - programming ones into the 16 random bytes has no effect
// - programming any zero into random bytes fails with program error
// - lock bytes 010-013 hold one bit per region; zero locks
// - reserved bytes 014-01F ship erased and accept programming
// - all one-time bytes except random number ship as FF
// - freeze bit set refuses all one-time programming
// - every separate space takes a full 24- or 32-bit address
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`include "faog_regs.svh"
module faog_otp_guard #(
   parameter logic [127:0] RANDOM_NUMBER =
      128'h0123456789abcdef0f1e2d3c4b5a6978,
   parameter logic [127:0] ID_ROM        =
      128'h00112233445566778899aabbccddeeff,
   parameter logic [63:0]  SFDP_HDR      = 64'h0706050403020100
) (
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   input  wire logic [7:0]                   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output logic [31:0]                       avs_readdata,
   output logic                              avs_waitrequest,
   output faog_pkg::faog_layout_e            layout,
   output logic                              otp_frozen
);
   import faog_pkg::*;

   // ID_ROM and the random number defaults are arbitrary values

   faog_state_s r_reg;
   faog_state_s r_next;

   logic        req;
   logic        take;
   logic [31:0] eff_addr;
   logic [9:0]  dec_idx;
   logic [26:0] dec_base;
   logic [8:0]  dec_kb;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] id_byte(input logic [31:0] a);
      logic [7:0] res;
      res = `FAOG_ERASED;
      if (a < `FAOG_ID_BYTES) begin
         res = ID_ROM[a[`FAOG_ID_AW-1:0]*8 +: 8];
      end
      return res;
   endfunction

   function automatic logic [7:0] sfdp_byte(input logic [31:0] a);
      logic [7:0]  res;
      logic [31:0] rel;
      res = `FAOG_ERASED;
      rel = a - {24'h000000, `FAOG_SFDP_ID_BASE};
      if (a < {24'h000000, `FAOG_SFDP_HDR_END}) begin
         res = SFDP_HDR[a[2:0]*8 +: 8];
      end else if (a >= {24'h000000, `FAOG_SFDP_ID_BASE}) begin
         res = id_byte(rel);
      end
      return res;
   endfunction

   function automatic faog_state_s reset_state();
      faog_state_s s;
      s = '0;
      for (int i = 0; i < `FAOG_OTP_BYTES; i++) begin
         s.otp[i] = `FAOG_ERASED;
      end
      for (int i = 0; i < `FAOG_OTP_RAND_END; i++) begin
         s.otp[i] = RANDOM_NUMBER[i*8 +: 8];
      end
      return s;
   endfunction

   assign req  = avs_read | avs_write;
   assign take = req & r_reg.ack;

   // one wait state per access; the answer is the second edge
   assign avs_waitrequest = req & ~r_reg.ack;
   assign avs_readdata    = r_reg.rdata;
   assign otp_frozen      = r_reg.freeze;

   // the address width follows the current mode in every space
   assign eff_addr = r_reg.addr4 ? r_reg.addr
                                 : (r_reg.addr & `FAOG_ADDR24_MASK);

   // both parameter layouts at once is unsupported; bottom wins
   always_comb begin
      if (r_reg.lo_bot) begin
         layout = FAOG_LY_BOTTOM;
      end else if (r_reg.up_top) begin
         layout = FAOG_LY_TOP;
      end else begin
         layout = FAOG_LY_UNIFORM;
      end
   end

   faog_sector_map u_map (
      .layout (layout),
      .addr   (eff_addr[26:0]),
      .idx    (dec_idx),
      .base   (dec_base),
      .kb     (dec_kb)
   );

   logic [7:0]  rd_byte;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_w;
   logic [9:0]  oa;
   logic [4:0]  region;
   logic [7:0]  lock_byte;
   logic        in_otp;
   logic        locked;
   logic        prog_fail;
   logic        prog_apply;
   faog_space_e space;
   logic        is_prog;
   logic        cmd_hit;
   logic        perr_set;
   logic        perr_clr;

   always_comb begin
      oa        = eff_addr[9:0];
      in_otp    = eff_addr < `FAOG_OTP_BYTES;
      region    = oa[`FAOG_REGION_MSB:`FAOG_REGION_LSB];
      lock_byte = r_reg.otp[`FAOG_OTP_LOCK0 + {7'h00, region[4:3]}];
      locked    = ~lock_byte[region[2:0]];
      space     = faog_space_e'(avs_writedata[`FAOG_CMD_SPACE]);
      is_prog   = avs_writedata[`FAOG_CMD_PROG];
      cmd_hit   = take & avs_write
                  & (avs_address == `FAOG_OFS_CMD) & avs_byteenable[0];
   end

   // program outcome for the one-time space
   always_comb begin
      prog_fail  = 1'b0;
      prog_apply = 1'b0;
      if (cmd_hit && is_prog) begin
         unique case (space)
            FAOG_SP_OTP: begin
               if (r_reg.freeze) begin
                  prog_fail = 1'b1;
               end else if (!in_otp) begin
                  prog_fail = 1'b1;
               end else if (oa < `FAOG_OTP_RAND_END) begin
                  prog_fail = ~&r_reg.wbyte;
               end else if (locked) begin
                  prog_fail = 1'b1;
               end else begin
                  prog_apply = 1'b1;
               end
            end
            FAOG_SP_ID, FAOG_SP_SFDP: begin
               prog_fail = 1'b1;
            end
            FAOG_SP_MAIN: begin
               prog_fail = 1'b0;
            end
         endcase
      end
   end

   // byte fetched by a read command
   always_comb begin
      rd_byte = `FAOG_ERASED;
      unique case (space)
         FAOG_SP_ID: begin
            rd_byte = id_byte(eff_addr);
         end
         FAOG_SP_SFDP: begin
            if (eff_addr[31:8] == 24'h000000) begin
               rd_byte = sfdp_byte(eff_addr);
            end
         end
         FAOG_SP_OTP: begin
            if (in_otp) begin
               rd_byte = r_reg.otp[oa];
            end
         end
         FAOG_SP_MAIN: begin
            rd_byte = `FAOG_ERASED;
         end
      endcase
   end

   // register read mux, unmapped offsets read zero
   always_comb begin
      ctrl_w = 32'h00000000;
      ctrl_w[`FAOG_CTRL_LO_BOT] = r_reg.lo_bot;
      ctrl_w[`FAOG_CTRL_UP_TOP] = r_reg.up_top;
      ctrl_w[`FAOG_CTRL_ADDR4]  = r_reg.addr4;
      rd_mux = 32'h00000000;
      unique case (avs_address)
         `FAOG_OFS_CTRL: begin
            rd_mux = ctrl_w;
         end
         `FAOG_OFS_ADDR: begin
            rd_mux = r_reg.addr;
         end
         `FAOG_OFS_WDATA: begin
            rd_mux = {24'h000000, r_reg.wbyte};
         end
         `FAOG_OFS_RDATA: begin
            rd_mux = {24'h000000, r_reg.rbyte};
         end
         `FAOG_OFS_STATUS: begin
            rd_mux[`FAOG_ST_PERR]    = r_reg.perr;
            rd_mux[`FAOG_ST_CFGBAD]  = r_reg.lo_bot & r_reg.up_top;
            rd_mux[`FAOG_ST_FREEZE]  = r_reg.freeze;
            rd_mux[`FAOG_ST_REFUSED] = r_reg.refused;
         end
         `FAOG_OFS_CONFIG_REG1_VOLATILE: begin
            rd_mux[`FAOG_CONFIG_REG1_VOLATILE_FREEZE] = r_reg.freeze;
         end
         `FAOG_OFS_SECTOR: begin
            rd_mux[`FAOG_SEC_IDX] = r_reg.sec_idx;
            rd_mux[`FAOG_SEC_KB]  = r_reg.sec_kb;
         end
         `FAOG_OFS_SECBASE: begin
            rd_mux = {5'h00, r_reg.sec_base};
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always_comb begin
      r_next     = r_reg;
      r_next.ack = req & ~r_reg.ack;
      perr_set   = prog_fail;
      perr_clr   = 1'b0;
      if (avs_read && !r_reg.ack) begin
         r_next.rdata = rd_mux;
      end
      if (take && avs_write) begin
         unique case (avs_address)
            `FAOG_OFS_CTRL: begin
               if (avs_byteenable[0]) begin
                  r_next.lo_bot = avs_writedata[`FAOG_CTRL_LO_BOT];
                  r_next.up_top = avs_writedata[`FAOG_CTRL_UP_TOP];
                  r_next.addr4  = avs_writedata[`FAOG_CTRL_ADDR4];
                  if (avs_writedata[`FAOG_CTRL_SWRST]) begin
                     r_next.freeze  = 1'b0;
                     r_next.refused = 1'b0;
                     perr_clr       = 1'b1;
                  end
               end
            end
            `FAOG_OFS_ADDR: begin
               r_next.addr = merge(r_reg.addr, avs_writedata,
                                   avs_byteenable);
            end
            `FAOG_OFS_WDATA: begin
               if (avs_byteenable[0]) begin
                  r_next.wbyte = avs_writedata[7:0];
               end
            end
            `FAOG_OFS_STATUS: begin
               if (avs_byteenable[0]) begin
                  perr_clr = avs_writedata[`FAOG_ST_PERR];
               end
            end
            `FAOG_OFS_CONFIG_REG1_VOLATILE: begin
               // set only: a zero written here never clears it
               if (avs_byteenable[0] &&
                   avs_writedata[`FAOG_CONFIG_REG1_VOLATILE_FREEZE]) begin
                  r_next.freeze = 1'b1;
               end
            end
            `FAOG_OFS_CMD: begin
               r_next.rbyte    = rd_byte;
               r_next.sec_idx  = dec_idx;
               r_next.sec_kb   = dec_kb;
               r_next.sec_base = dec_base;
               if (is_prog) begin
                  r_next.refused = prog_fail;
               end
            end
            default: begin
               r_next.ack = r_next.ack;
            end
         endcase
      end
      // programming only clears bits, one byte per command
      if (prog_apply) begin
         r_next.otp[oa] = r_reg.otp[oa] & r_reg.wbyte;
      end
      // a new error outranks a clear in the same cycle
      if (perr_clr) begin
         r_next.perr = 1'b0;
      end
      if (perr_set) begin
         r_next.perr = 1'b1;
      end
   end

   // reset stands for power-on: it also restores the factory image
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r_reg <= reset_state();
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// file: hw/faog_pkg.sv
`include "faog_regs.svh"
package faog_pkg;
   typedef enum logic [1:0] {
      FAOG_SP_MAIN = 2'b00,
      FAOG_SP_ID   = 2'b01,
      FAOG_SP_SFDP = 2'b10,
      FAOG_SP_OTP  = 2'b11
   } faog_space_e;
   typedef enum logic [1:0] {
      FAOG_LY_UNIFORM = 2'b00,
      FAOG_LY_BOTTOM  = 2'b01,
      FAOG_LY_TOP     = 2'b10
   } faog_layout_e;
   typedef struct packed {
      logic                              ack;
      logic [31:0]                       rdata;
      logic                              lo_bot;
      logic                              up_top;
      logic                              addr4;
      logic [31:0]                       addr;
      logic [7:0]                        wbyte;
      logic [7:0]                        rbyte;
      logic                              perr;
      logic                              refused;
      logic                              freeze;
      logic [9:0]                        sec_idx;
      logic [8:0]                        sec_kb;
      logic [26:0]                       sec_base;
      logic [`FAOG_OTP_BYTES-1:0][7:0]   otp;
   } faog_state_s;
endpackage

// file: hw/faog_regs.svh
`ifndef FAOG_REGS_SVH
`define FAOG_REGS_SVH
`define FAOG_OFS_CTRL     8'h00
`define FAOG_OFS_ADDR     8'h04
`define FAOG_OFS_CMD      8'h08
`define FAOG_OFS_WDATA    8'h0c
`define FAOG_OFS_RDATA    8'h10
`define FAOG_OFS_STATUS   8'h14
`define FAOG_OFS_CONFIG_REG1_VOLATILE 8'h18
`define FAOG_OFS_SECTOR   8'h1c
`define FAOG_OFS_SECBASE  8'h20
`define FAOG_CTRL_LO_BOT  0
`define FAOG_CTRL_UP_TOP  1
`define FAOG_CTRL_ADDR4   2
`define FAOG_CTRL_SWRST   3
`define FAOG_CMD_SPACE    1:0
`define FAOG_CMD_PROG     4
`define FAOG_ST_PERR      0
`define FAOG_ST_CFGBAD    1
`define FAOG_ST_FREEZE    2
`define FAOG_ST_REFUSED   3
`define FAOG_CONFIG_REG1_VOLATILE_FREEZE 0
`define FAOG_SEC_KB       24:16
`define FAOG_SEC_IDX      9:0
`define FAOG_OTP_BYTES    1024
`define FAOG_OTP_RAND_END 10'h010
`define FAOG_OTP_LOCK0    10'h010
`define FAOG_REGION_MSB   9
`define FAOG_REGION_LSB   5
`define FAOG_ID_BYTES     16
`define FAOG_ID_AW        4
`define FAOG_SFDP_ID_BASE 8'h80
`define FAOG_SFDP_HDR_END 8'h08
`define FAOG_ERASED       8'hff
`define FAOG_ADDR24_MASK  32'h00ffffff
`define FAOG_PAR_END      27'h0008000
`define FAOG_BIG_END      27'h0040000
`define FAOG_TOP_BIG_END  27'h7fc0000
`define FAOG_TOP_PAR      27'h7ff8000
`define FAOG_SH_4K        12
`define FAOG_SH_256K      18
`define FAOG_PAR_CNT      10'd8
`define FAOG_IDX_224_TOP  10'd511
`define FAOG_KB_4         9'd4
`define FAOG_KB_224       9'd224
`define FAOG_KB_256       9'd256
`endif

// file: hw/faog_sector_map.sv
`include "faog_regs.svh"
module faog_sector_map (
   input  wire faog_pkg::faog_layout_e layout,
   input  wire logic [26:0]            addr,
   output logic [9:0]                  idx,
   output logic [26:0]                 base,
   output logic [8:0]                  kb
);
   import faog_pkg::*;
   logic [26:0] base_4k;
   logic [26:0] base_256k;
   logic [9:0]  big_idx;
   always_comb begin
      base_4k   = {addr[26:`FAOG_SH_4K], {`FAOG_SH_4K{1'b0}}};
      base_256k = {addr[26:`FAOG_SH_256K], {`FAOG_SH_256K{1'b0}}};
      big_idx   = {1'b0, addr[26:`FAOG_SH_256K]};
      idx       = big_idx;
      base      = base_256k;
      kb        = `FAOG_KB_256;
      unique case (layout)
         FAOG_LY_BOTTOM: begin
            if (addr < `FAOG_PAR_END) begin
               idx  = {7'h00, addr[14:`FAOG_SH_4K]};
               base = base_4k;
               kb   = `FAOG_KB_4;
            end else if (addr < `FAOG_BIG_END) begin
               idx  = `FAOG_PAR_CNT;
               base = `FAOG_PAR_END;
               kb   = `FAOG_KB_224;
            end else begin
               idx  = big_idx + `FAOG_PAR_CNT;
            end
         end
         FAOG_LY_TOP: begin
            if (addr >= `FAOG_TOP_PAR) begin
               idx  = `FAOG_IDX_224_TOP + 10'd1
                      + {7'h00, addr[14:`FAOG_SH_4K]};
               base = base_4k;
               kb   = `FAOG_KB_4;
            end else if (addr >= `FAOG_TOP_BIG_END) begin
               idx  = `FAOG_IDX_224_TOP;
               base = `FAOG_TOP_BIG_END;
               kb   = `FAOG_KB_224;
            end
         end
         FAOG_LY_UNIFORM: begin
            idx = big_idx;
         end
         default: begin
            idx = big_idx;
         end
      endcase
   end
endmodule

// file: tb/faog_host.sv
`include "faog_regs.svh"
module faog_host (
   input  wire logic        clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   output logic [7:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
   end
   // full 32-bit word always carried, masking is the device's job
   task automatic xfer(input logic [7:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         tb_top.n_errors++;
         tb_top.wrap_up();
      end
   endtask
   // never both parameter layouts at once
   task automatic cfg(input logic bot, input logic top, input logic a4);
      logic [31:0] q;
      if (bot && top) begin
         top = 1'b0;
      end
      xfer(`FAOG_OFS_CTRL, 1'b1, {29'h0, a4, top, bot}, q);
   endtask
endmodule

// file: tb/faog_otp_guard_asserts.sv
`include "faog_regs.svh"
module faog_otp_guard_asserts
   import faog_pkg::*;
(
   input wire logic         clk,
   input wire logic         reset_n,
   input wire logic [7:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [31:0]  avs_writedata,
   input wire logic [3:0]   avs_byteenable,
   input wire logic [31:0]  avs_readdata,
   input wire logic         avs_waitrequest,
   input wire faog_layout_e layout,
   input wire logic         otp_frozen
);
   logic acc;
   logic ctrl_wr;
   logic cr1_wr;
   assign acc = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign ctrl_wr = acc & (avs_address == `FAOG_OFS_CTRL);
   assign cr1_wr = acc & (avs_address == `FAOG_OFS_CONFIG_REG1_VOLATILE);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_WAIT_ONE: assert property ((avs_read | avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait not one cycle");
   AST_LAY_BOT: assert property (ctrl_wr && avs_writedata[0]
      |=> layout == FAOG_LY_BOTTOM) else $error("bottom layout missed");
   AST_LAY_TOP: assert property (ctrl_wr && avs_writedata[1:0] == 2'b10
      |=> layout == FAOG_LY_TOP) else $error("top layout missed");
   AST_LAY_UNI: assert property (ctrl_wr && avs_writedata[1:0] == 2'b00
      |=> layout == FAOG_LY_UNIFORM) else $error("uniform layout missed");
   AST_LAY_HOLD: assert property (!ctrl_wr |=> $stable(layout))
      else $error("layout moved without write");
   AST_RST_CLEAN: assert property ($rose(reset_n)
      |-> layout == FAOG_LY_UNIFORM && !otp_frozen)
      else $error("reset state wrong");
   AST_FRZ_SET: assert property (cr1_wr && avs_writedata[0]
      |=> otp_frozen) else $error("freeze not set");
   AST_FRZ_STICK: assert property (otp_frozen
      && !(ctrl_wr && avs_writedata[3]) |=> otp_frozen)
      else $error("freeze dropped");
   AST_FRZ_LOW: assert property (!otp_frozen
      && !(cr1_wr && avs_writedata[0]) |=> !otp_frozen)
      else $error("freeze set without cause");
endmodule
bind faog_otp_guard faog_otp_guard_asserts chk_i (
   .clk             (clk),
   .reset_n         (reset_n),
   .avs_address     (avs_address),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_writedata   (avs_writedata),
   .avs_byteenable  (avs_byteenable),
   .avs_readdata    (avs_readdata),
   .avs_waitrequest (avs_waitrequest),
   .layout          (layout),
   .otp_frozen      (otp_frozen)
);

// file: tb/tb_top.sv
`include "faog_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import faog_pkg::*;
   localparam logic [127:0] RN = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
   localparam logic [127:0] ID = 128'h1f2e3d4c5b6a79880011223344556677;
   localparam logic [63:0] HDR = 64'h8877665544332211;
   logic         clk;
   logic         reset_n;
   logic [7:0]   avs_address;
   logic         avs_read;
   logic         avs_write;
   logic [31:0]  avs_writedata;
   logic [3:0]   avs_byteenable;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   faog_layout_e layout;
   logic         otp_frozen;
   int           n_errors;
   int           checks;
   faog_otp_guard #(.RANDOM_NUMBER(RN), .ID_ROM(ID), .SFDP_HDR(HDR))
   faog_otp_guard_i (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .layout(layout),
      .otp_frozen(otp_frozen));
   faog_host host_i (.clk(clk), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up;
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host_i.xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      host_i.xfer(a, 1'b0, 32'h0, q);
   endtask
   task automatic prg(input logic [1:0] sp, input logic [31:0] a,
                      input logic [7:0] d);
      wr(`FAOG_OFS_ADDR, a);
      wr(`FAOG_OFS_WDATA, {24'h0, d});
      wr(`FAOG_OFS_CMD, {27'h0, 1'b1, 2'b00, sp});
   endtask
   task automatic ckb(input logic [1:0] sp, input logic [31:0] a,
                      input logic [7:0] e);
      logic [31:0] q;
      wr(`FAOG_OFS_ADDR, a);
      wr(`FAOG_OFS_CMD, {30'h0, sp});
      rd(`FAOG_OFS_RDATA, q);
      chk(q & 32'hff, {24'h0, e});
   endtask
   // clears the flag after looking, so each check stands alone
   task automatic perr(input logic e);
      logic [31:0] q;
      rd(`FAOG_OFS_STATUS, q);
      chk({31'h0, q[0]}, {31'h0, e});
      wr(`FAOG_OFS_STATUS, 32'h1);
   endtask
   task automatic sec(input logic bot, input logic top, input logic a4,
                      input logic [31:0] a, input logic [9:0] i,
                      input logic [8:0] k, input logic [26:0] b);
      logic [31:0] q;
      host_i.cfg(bot, top, a4);
      wr(`FAOG_OFS_ADDR, a);
      wr(`FAOG_OFS_CMD, 32'h0);
      rd(`FAOG_OFS_SECTOR, q);
      chk(q & 32'h01ff03ff, {7'h0, k, 6'h0, i});
      rd(`FAOG_OFS_SECBASE, q);
      chk(q & 32'h07ffffff, {5'h0, b});
   endtask
   task automatic t_sec;
      sec(1, 0, 1, 32'h7000, 10'd7, 9'd4, 27'h7000);
      sec(1, 0, 1, 32'h8000, 10'd8, 9'd224, 27'h8000);
      sec(1, 0, 1, 32'h41000, 10'd9, 9'd256, 27'h40000);
      sec(1, 0, 1, 32'h7ffffff, 10'd519, 9'd256, 27'h7fc0000);
      sec(0, 1, 1, 32'h7fbffff, 10'd510, 9'd256, 27'h7f80000);
      sec(0, 1, 1, 32'h7ff7fff, 10'd511, 9'd224, 27'h7fc0000);
      sec(0, 1, 1, 32'h7fff123, 10'd519, 9'd4, 27'h7fff000);
      sec(0, 0, 1, 32'h7ffffff, 10'd511, 9'd256, 27'h7fc0000);
      sec(0, 0, 1, 32'h40000, 10'd1, 9'd256, 27'h40000);
      sec(1, 0, 0, 32'h7f008000, 10'd8, 9'd224, 27'h8000);
   endtask
   task automatic t_rom;
      ckb(1, 0, ID[7:0]);
      ckb(1, 15, ID[127:120]);
      ckb(1, 16, 8'hff);
      prg(1, 0, 8'h00);
      perr(1);
      ckb(1, 0, ID[7:0]);
      ckb(2, 3, HDR[31:24]);
      ckb(2, 32'h80, ID[7:0]);
      ckb(2, 32'h8f, ID[127:120]);
      ckb(2, 32'h100, 8'hff);
   endtask
   task automatic t_otp;
      ckb(3, 5, RN[47:40]);
      ckb(3, 32'h10, 8'hff);
      ckb(3, 32'h3ff, 8'hff);
      prg(3, 0, 8'hff);
      ckb(3, 0, RN[7:0]);
      perr(0);
      prg(3, 1, 8'hfe);
      ckb(3, 1, RN[15:8]);
      perr(1);
      prg(3, 32'h14, 8'h0f);
      ckb(3, 32'h14, 8'h0f);
      perr(0);
      prg(3, 32'h20, 8'h5a);
      ckb(3, 32'h20, 8'h5a);
      prg(3, 32'h10, 8'hfd);
      prg(3, 32'h21, 8'h00);
      ckb(3, 32'h21, 8'hff);
      perr(1);
      prg(3, 32'h13, 8'h7f);
      prg(3, 32'h3e0, 8'h00);
      ckb(3, 32'h3e0, 8'hff);
      perr(1);
      prg(3, 32'h3c0, 8'h00);
      ckb(3, 32'h3c0, 8'h00);
      perr(0);
      prg(3, 32'h400, 8'h00);
      perr(1);
   endtask
   task automatic t_frz;
      logic [31:0] q;
      wr(`FAOG_OFS_CONFIG_REG1_VOLATILE, 32'h1);
      #1;
      chk({31'h0, otp_frozen}, 32'h1);
      prg(3, 32'h40, 8'h00);
      ckb(3, 32'h40, 8'hff);
      rd(`FAOG_OFS_STATUS, q);
      chk(q & 32'hf, 32'hd);
      perr(1);
      wr(`FAOG_OFS_CONFIG_REG1_VOLATILE, 32'h0);
      #1;
      chk({31'h0, otp_frozen}, 32'h1);
      wr(`FAOG_OFS_CTRL, 32'h8);
      #1;
      chk({31'h0, otp_frozen}, 32'h0);
      rd(`FAOG_OFS_CONFIG_REG1_VOLATILE, q);
      chk(q, 32'h0);
      prg(3, 32'h40, 8'h00);
      ckb(3, 32'h40, 8'h00);
   endtask
   // power-on again: the image must come back, not the programmed bytes
   task automatic t_rst;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      ckb(3, 32'h20, 8'hff);
      ckb(3, 32'h10, 8'hff);
      chk({30'h0, layout}, {30'h0, FAOG_LY_UNIFORM});
   endtask
   initial begin
      reset_n = 1'b0;
      n_errors = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_sec();
      t_rom();
      t_otp();
      t_frz();
      t_rst();
      wrap_up();
   end
endmodule
